// >>> rtl/fer_regs.sv
// Top: feature words and enable/exception register with access gating
`default_nettype none
module fer_regs (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire fer_pkg::fer_access_t i_acc,
  input wire fer_pkg::fer_xfer_t i_xfer,
  input wire fer_pkg::fer_instr_t i_instr,
  input wire logic i_other_undef,
  output logic o_xfer_accept,
  output logic o_xfer_refuse,
  output logic [31:0] o_rdata,
  output logic o_instr_accept,
  output logic o_instr_bounce,
  output logic o_unit_en
);
  import fer_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  logic [31:0] cap_low;
  logic [31:0] cap_high;
  logic allowed;
  logic enable_q;
  logic enable_d;
  logic bounce_q;
  logic bounce_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  fer_caps u_caps (
    .o_cap_low(cap_low),
    .o_cap_high(cap_high)
  );

  fer_access u_access (
    .i_acc(i_acc),
    .i_sel(i_xfer.sel),
    .i_unit_en(enable_q),
    .o_allowed(allowed)
  );

  // Capability writes are refused: they are read-only words
  logic legal;
  assign legal = allowed &&
    (!i_xfer.write || i_xfer.sel == FER_SEL_ENABLE);
  assign o_xfer_accept = i_xfer.valid && legal;
  assign o_xfer_refuse = i_xfer.valid && !legal;

  // Disabled unit bounces every data instruction; vectors always bounce
  logic vec_bounce;
  assign vec_bounce = i_instr.valid && i_instr.is_vector;
  assign o_instr_bounce = i_instr.valid &&
    (i_instr.is_vector || (i_instr.is_data && !enable_q));
  assign o_instr_accept = i_instr.valid && !o_instr_bounce;

  // ----------------------------------------------------------------
  // Next-state for enable, bounce flag and read data
  // ----------------------------------------------------------------
  always_comb begin
    enable_d = enable_q;
    bounce_d = bounce_q;
    rdata_d = rdata_q;
    if (o_xfer_accept && i_xfer.write) begin
      // Bit 31 and 28..0 are not stored at all
      enable_d = i_xfer.wdata[FER_ENABLE_BIT];
      bounce_d = i_xfer.wdata[FER_BOUNCE_BIT];
    end
    // Hardware events win over a software write in the same cycle
    if (i_other_undef) begin
      bounce_d = 1'b0;
    end
    if (vec_bounce) begin
      bounce_d = 1'b1;
    end
    if (o_xfer_accept && !i_xfer.write) begin
      case (i_xfer.sel)
        FER_SEL_CAP_LOW: begin
          rdata_d = cap_low;
        end
        FER_SEL_CAP_HIGH: begin
          rdata_d = cap_high;
        end
        FER_SEL_ENABLE: begin
          rdata_d = 32'h0000_0000;
          rdata_d[FER_ENABLE_BIT] = enable_q;
          rdata_d[FER_BOUNCE_BIT] = bounce_q;
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // Registers; enable clears on reset
  always_ff @(posedge i_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      enable_q <= FER_ENABLE_RST;
      bounce_q <= FER_BOUNCE_RST;
      rdata_q <= 32'h0000_0000;
    end else begin
      enable_q <= enable_d;
      bounce_q <= bounce_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_unit_en = enable_q;
endmodule
`default_nettype wire

// >>> rtl/fer_pkg.sv
// Package of constants and types for the unit feature and enable registers
// Behaviour
// - Low word: all rounding, no short vectors
// - Low word: square root and divide supported
// - Low word: exception trapping not supported
// - Low word: double and single precision supported
// - Low word: sixteen 64-bit registers
// - High word: fused multiply-accumulate, scalar half precision
// - High word: packed-SIMD features all absent
// - High word: NaN propagation, full subnormal arithmetic
// - Capability reads: privileged, access enabled, unit enabled
// - Non-secure access needs both coprocessor bits
// - Enable register: privileged, access enabled only
// - Bits 31 and 28..0 read zero
// - Bit 30 is unit enable, reset zero
// - Vector bounce sets bit 29
// - Other undefined exceptions clear bit 29; a vector bounce in the same cycle sets it instead
// - Bounce means refusing a valid instruction
`default_nettype none
package fer_pkg;
  // ----------------------------------------------------------------
  // Register selectors on the transfer port
  // ----------------------------------------------------------------
  localparam logic [1:0] FER_SEL_CAP_LOW = 2'h0;
  localparam logic [1:0] FER_SEL_CAP_HIGH = 2'h1;
  localparam logic [1:0] FER_SEL_ENABLE = 2'h2;

  // ----------------------------------------------------------------
  // Capability nibble encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] FER_NIB_NONE = 4'h0;
  localparam logic [3:0] FER_NIB_YES = 4'h1;
  localparam logic [3:0] FER_NIB_DOUBLE = 4'h2;
  localparam logic [3:0] FER_NIB_REGS16 = 4'h1;

  // ----------------------------------------------------------------
  // Enable register fields and reset values
  // ----------------------------------------------------------------
  localparam int FER_ASYNC_BIT = 31;
  localparam int FER_ENABLE_BIT = 30;
  localparam int FER_BOUNCE_BIT = 29;
  localparam logic FER_ENABLE_RST = 1'b0;
  localparam logic FER_BOUNCE_RST = 1'b0;

  // Access control inputs
  typedef struct packed {
    logic privileged;   // Core in a privileged mode
    logic nonsecure;    // Core in non-secure state
    logic cpa_ten;      // Access control grants coprocessor ten
    logic cpa_eleven;   // Access control grants coprocessor eleven
    logic nsa_ten;      // Non-secure control grants coprocessor ten
    logic nsa_eleven;   // Non-secure control grants coprocessor eleven
  } fer_access_t;

  // Register transfer request from the core
  typedef struct packed {
    logic valid;        // Transfer offered
    logic write;        // 1 = move from core, 0 = move to core
    logic [1:0] sel;    // Register selector
    logic [31:0] wdata; // Write data
  } fer_xfer_t;

  // Instruction offer from the core
  typedef struct packed {
    logic valid;        // Instruction offered
    logic is_vector;    // Short-vector operation
    logic is_data;      // Data processing or load/store
  } fer_instr_t;
endpackage
`default_nettype wire

// >>> rtl/fer_access.sv
// Access permission check for one register transfer
`default_nettype none
module fer_access (
  input wire fer_pkg::fer_access_t i_acc,
  input wire logic [1:0] i_sel,
  input wire logic i_unit_en,
  output logic o_allowed
);
  import fer_pkg::*;
  logic base_ok;
  // ----------------------------------------------------------------
  // Permission logic
  // ----------------------------------------------------------------
  always_comb begin
    // Privileged, both coprocessors granted
    base_ok = i_acc.privileged && i_acc.cpa_ten && i_acc.cpa_eleven;
    // Non-secure needs both non-secure grants
    if (i_acc.nonsecure && !(i_acc.nsa_ten && i_acc.nsa_eleven)) begin
      base_ok = 1'b0;
    end
    case (i_sel)
      FER_SEL_CAP_LOW, FER_SEL_CAP_HIGH: begin
        o_allowed = base_ok && i_unit_en;
      end
      FER_SEL_ENABLE: begin
        o_allowed = base_ok;
      end
      default: begin
        o_allowed = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// >>> rtl/fer_caps.sv
// Constant capability words
`default_nettype none
module fer_caps (
  output logic [31:0] o_cap_low,
  output logic [31:0] o_cap_high
);
  import fer_pkg::*;
  // ----------------------------------------------------------------
  // Fixed values: nothing stores them, so writes cannot alter them
  // ----------------------------------------------------------------
  assign o_cap_low = {FER_NIB_YES, FER_NIB_NONE,
                      FER_NIB_YES, FER_NIB_YES,
                      FER_NIB_NONE,
                      FER_NIB_DOUBLE, FER_NIB_DOUBLE,
                      FER_NIB_REGS16};
  assign o_cap_high = {FER_NIB_YES, FER_NIB_YES,
                       FER_NIB_NONE, FER_NIB_NONE,
                       FER_NIB_NONE, FER_NIB_NONE,
                       FER_NIB_YES, FER_NIB_YES};
endmodule
`default_nettype wire

// >>> verif/fer_regs_monitor.sv
// Checker of the feature and enable register ports
`default_nettype none
module fer_regs_monitor (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire fer_pkg::fer_access_t i_acc,
  input wire fer_pkg::fer_xfer_t i_xfer,
  input wire fer_pkg::fer_instr_t i_instr,
  input wire logic o_xfer_accept,
  input wire logic o_xfer_refuse,
  input wire logic [31:0] o_rdata,
  input wire logic o_instr_bounce,
  input wire logic o_unit_en
);
  import fer_pkg::*;
  logic v, w;
  logic [1:0] s;
  assign v = i_xfer.valid;
  assign w = i_xfer.write;
  assign s = i_xfer.sel;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  a_cap_write_ro: assert property (v && w && !s[1] |-> o_xfer_refuse)
    else $error("cap write taken");
  a_priv_needed: assert property (v && !i_acc.privileged |-> o_xfer_refuse)
    else $error("user access taken");
  a_cap_needs_en: assert property (v && !w && !s[1] && !o_unit_en
    |-> o_xfer_refuse) else $error("cap read while off");
  a_low_word: assert property (o_xfer_accept && !w && s == 0
    |=> o_rdata == 32'h1011_0221) else $error("low word");
  a_high_word: assert property (o_xfer_accept && !w && s == 1
    |=> o_rdata == 32'h1100_0011) else $error("high word");
  a_en_write: assert property (o_xfer_accept && w && s == 2
    |=> o_unit_en == $past(i_xfer.wdata[30])) else $error("enable");
  a_vec_bounce: assert property (i_instr.valid && i_instr.is_vector
    |-> o_instr_bounce) else $error("vector taken");
  a_off_bounce: assert property (i_instr.valid && i_instr.is_data
    && !o_unit_en |-> o_instr_bounce) else $error("taken while off");
  a_ns_grant: assert property (v && i_acc.nonsecure
    && !(i_acc.nsa_ten && i_acc.nsa_eleven) |-> o_xfer_refuse)
    else $error("non-secure access taken");
  a_en_zeros: assert property (o_xfer_accept && !w && s == 2'h2
    |=> o_rdata[31] == 1'b0 && o_rdata[28:0] == 29'h0000_0000)
    else $error("reserved bits set");
  a_one_answer: assert property (v
    |-> o_xfer_accept != o_xfer_refuse) else $error("answer clash");
  c_refuse: cover property (o_xfer_refuse);
  c_bounce: cover property (o_instr_bounce);
  c_enable: cover property ($rose(o_unit_en));
endmodule
bind fer_regs fer_regs_monitor mon (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_acc(i_acc), .i_xfer(i_xfer), .i_instr(i_instr),
  .o_xfer_accept(o_xfer_accept), .o_xfer_refuse(o_xfer_refuse),
  .o_rdata(o_rdata), .o_instr_bounce(o_instr_bounce),
  .o_unit_en(o_unit_en));
`default_nettype wire

// >>> verif/fer_host.sv
// Host core model issuing register move instructions
`default_nettype none
module fer_host (
  input wire logic i_clk,
  input wire logic i_accept,
  input wire logic [31:0] i_rdata,
  output var fer_pkg::fer_access_t o_acc,
  output var fer_pkg::fer_xfer_t o_xfer
);
  timeunit 1ns;
  timeprecision 1ns;
  import fer_pkg::*;
  initial begin
    o_acc = '0;
    o_xfer = '0;
  end
  // One transfer; data inverted after so a stale word is never trusted
  task automatic xfer(input logic [5:0] a, input logic wr,
    input logic [1:0] s, input logic [31:0] d,
    output logic ok, output logic [31:0] rd);
    @(posedge i_clk);
    o_acc <= a;
    o_xfer <= {1'b1, wr, s, d};
    @(posedge i_clk);
    ok = i_accept;
    o_xfer.valid <= 1'b0;
    o_xfer.wdata <= ~d;
    @(negedge i_clk);
    rd = i_rdata;
  endtask
endmodule
`default_nettype wire

// >>> verif/fer_regs_tb.sv
// Self-checking bench of the feature and enable registers
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
  num_errors++; $display("unexpected at %0t: %h", $time, a); end end
module fer_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fer_pkg::*;
  typedef struct packed {
    logic [5:0] acc;
    logic [1:0] sel;
    logic ok;
    logic [31:0] rd;
  } fer_row_t;
  logic clk, arst_n, undef, ok, x_ok, x_no, in_ok, bnc, en;
  logic [31:0] rd, rdata;
  fer_access_t acc;
  fer_xfer_t xfer;
  fer_instr_t instr;
  int num_errors = 0;
  int tests_run = 0;
  fer_row_t rows [7] = '{'{6'h2C, 2'h0, 1'b1, 32'h1011_0221},
    '{6'h0C, 2'h0, 1'b0, 32'h1011_0221}, '{6'h3F, 2'h1, 1'b1, 32'h1100_0011},
    '{6'h28, 2'h1, 1'b0, 32'h1100_0011}, '{6'h3E, 2'h2, 1'b0, 32'h1100_0011},
    '{6'h3F, 2'h2, 1'b1, 32'h4000_0000}, '{6'h2C, 2'h3, 1'b0, 32'h4000_0000}};
  fer_regs uut (.i_clk(clk), .i_arst_n(arst_n), .i_acc(acc), .i_xfer(xfer),
    .i_instr(instr), .i_other_undef(undef), .o_xfer_accept(x_ok),
    .o_xfer_refuse(x_no), .o_rdata(rdata), .o_instr_accept(in_ok),
    .o_instr_bounce(bnc), .o_unit_en(en));
  fer_host host (.i_clk(clk), .i_accept(x_ok), .i_rdata(rdata),
    .o_acc(acc), .o_xfer(xfer));
  task automatic end_of_test;
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Offer one instruction and check accept against bounce
  task automatic offer(input logic v, input logic d, input logic b);
    @(posedge clk);
    instr <= {1'b1, v, d};
    @(negedge clk);
    `CHK({in_ok, bnc}, {~b, b})
    @(posedge clk);
    instr <= '0;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #200_000;
    num_errors++;
    end_of_test;
  end
  initial begin
    arst_n = 1'b0;
    undef = 1'b0;
    instr = '0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(en, 1'b0)
    host.xfer(6'h2C, 1'b0, 2'h0, '0, ok, rd);
    `CHK(ok, 1'b0)
    offer(1'b0, 1'b1, 1'b1);
    host.xfer(6'h2C, 1'b1, 2'h0, 32'hFFFF_FFFF, ok, rd);
    `CHK(ok, 1'b0)
    host.xfer(6'h2C, 1'b1, 2'h2, 32'hDFFF_FFFF, ok, rd);
    `CHK({ok, en}, 2'b11)
    // Table of reads under five access settings
    foreach (rows[i]) begin
      host.xfer(rows[i].acc, 1'b0, rows[i].sel, '0, ok, rd);
      `CHK({ok, rd}, {rows[i].ok, rows[i].rd})
    end
    offer(1'b1, 1'b1, 1'b1);
    host.xfer(6'h2C, 1'b0, 2'h2, '0, ok, rd);
    `CHK(rd, 32'h6000_0000)
    @(posedge clk);
    undef <= 1'b1;
    @(posedge clk);
    undef <= 1'b0;
    host.xfer(6'h2C, 1'b0, 2'h2, '0, ok, rd);
    `CHK(rd, 32'h4000_0000)
    offer(1'b0, 1'b1, 1'b0);
    // Reset in mid-run must drop the enable bit again
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    `CHK(en, 1'b0)
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    host.xfer(6'h2C, 1'b1, 2'h2, 32'h4000_0000, ok, rd);
    `CHK({ok, en}, 2'b11)
    // Software disable, then data bounces and non-data instructions still pass
    host.xfer(6'h2C, 1'b1, 2'h2, '0, ok, rd);
    `CHK({ok, en}, 2'b10)
    offer(1'b0, 1'b1, 1'b1);
    offer(1'b0, 1'b0, 1'b0);
    end_of_test;
  end
endmodule
`default_nettype wire
